// >>> core/tac_conv_engine.sv
module tac_conv_engine #(
  parameter int unsigned PERIOD_8SPS = tac_pkg::CONV_8SPS_CYCLES
) (
  input  wire logic               sys_clk,
  input  wire logic               rstn,
  input  wire logic               continuous,
  input  wire logic               start_single,
  input  wire logic [2:0]         rate_sel,
  input  wire logic [2:0]         gain_sel,
  input  wire logic signed [15:0] sample_in,
  output logic signed [15:0]      result_reg,
  output logic                    done_reg,
  output logic                    busy_reg
);
  import tac_pkg::*;

  logic [31:0] cnt_reg;
  logic [31:0] period;
  logic        run;
  logic        last;

  function automatic logic [2:0] rate_shift(input logic [2:0] code);
    unique case (code)
      DR_8SPS:  rate_shift = 3'h0;
      DR_16SPS: rate_shift = 3'h1;
      DR_32SPS: rate_shift = 3'h2;
      DR_64SPS: rate_shift = 3'h3;
      default:  rate_shift = 3'h4;
    endcase
  endfunction : rate_shift

  // raw sample has 6.144 V full scale; gain stretches and saturates
  function automatic logic signed [15:0] scale(input logic signed [15:0] s,
                                               input logic [2:0] g);
    logic signed [21:0] p;
    logic signed [5:0]  k;
    p = 22'sh0;
    unique case (g)
      PGA_6V144: k = 6'sh02;
      PGA_4V096: k = 6'sh03;
      PGA_2V048: k = 6'sh06;
      PGA_1V024: k = 6'sh0c;
      default:   k = 6'sh18;
    endcase
    p = (22'(s) * 22'(k)) >>> 1;
    if (p > 22'sh007fff) scale = 16'sh7fff;
    else if (p < -22'sh008000) scale = -16'sh8000;
    else scale = p[15:0];
  endfunction : scale

  assign period = 32'(PERIOD_8SPS >> rate_shift(rate_sel));
  assign run    = continuous | busy_reg;
  assign last   = run && (cnt_reg == period - 32'h1);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= 32'h0;
    end else if (!run || last) begin
      cnt_reg <= 32'h0;
    end else begin
      cnt_reg <= cnt_reg + 32'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      busy_reg <= 1'b0;
    end else if (continuous) begin
      busy_reg <= 1'b0;
    end else if (start_single && !busy_reg) begin
      busy_reg <= 1'b1;
    end else if (last) begin
      busy_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      done_reg   <= 1'b0;
      result_reg <= 16'sh0;
    end else begin
      done_reg <= last;
      if (last) result_reg <= scale(sample_in, gain_sel);
    end
  end

  chk_rate_period_done: assert property (@(posedge sys_clk) disable iff (!rstn)
    last |=> done_reg) else $error("conversion end not flagged");
  chk_single_shot_stop: assert property (@(posedge sys_clk) disable iff (!rstn)
    (last && !continuous) ##1 !continuous |-> !busy_reg)
    else $error("single shot did not power down");
  chk_gain_unity_scale: assert property (@(posedge sys_clk) disable iff (!rstn)
    (last && gain_sel == PGA_6V144) |=> result_reg == $past(sample_in))
    else $error("full range result mis-scaled");
endmodule : tac_conv_engine

// >>> core/tac_pkg.sv
package tac_pkg;
  localparam int unsigned CLK_HZ           = 40_000_000;
  localparam int unsigned CLK_MHZ          = CLK_HZ / 1_000_000;
  // register pointer values on the serial bus
  localparam logic [1:0]  PTR_CONV         = 2'h0;
  localparam logic [1:0]  PTR_CFG          = 2'h1;
  localparam logic [1:0]  PTR_LO           = 2'h2;
  localparam logic [1:0]  PTR_HI           = 2'h3;
  // values after reset
  localparam logic [15:0] CFG_RESET        = 16'h8583;
  localparam logic [15:0] LO_RESET         = 16'h8000;
  localparam logic [15:0] HI_RESET         = 16'h7fff;
  // configuration field positions
  localparam int          CFG_OS_BIT       = 15;
  localparam int          CFG_PGA_LSB      = 9;
  localparam int          CFG_MODE_BIT     = 8;
  localparam int          CFG_DR_LSB       = 5;
  localparam int          CFG_CMODE_BIT    = 4;
  localparam int          CFG_POL_BIT      = 3;
  localparam int          CFG_LAT_BIT      = 2;
  localparam int          CFG_QUE_LSB      = 0;
  // comparator queue codes
  localparam logic [1:0]  QUE_ONE          = 2'h0;
  localparam logic [1:0]  QUE_TWO          = 2'h1;
  localparam logic [1:0]  QUE_FOUR         = 2'h2;
  localparam logic [1:0]  QUE_DISABLE      = 2'h3;
  // gain range codes
  localparam logic [2:0]  PGA_6V144        = 3'h0;
  localparam logic [2:0]  PGA_4V096        = 3'h1;
  localparam logic [2:0]  PGA_2V048        = 3'h2;
  localparam logic [2:0]  PGA_1V024        = 3'h3;
  // rate codes
  localparam logic [2:0]  DR_8SPS          = 3'h0;
  localparam logic [2:0]  DR_16SPS         = 3'h1;
  localparam logic [2:0]  DR_32SPS         = 3'h2;
  localparam logic [2:0]  DR_64SPS         = 3'h3;
  localparam int unsigned SPS_SLOWEST      = 8;
  localparam int unsigned CONV_8SPS_CYCLES = CLK_HZ / SPS_SLOWEST;
  // ready pulse width, a least time, so rounded up
  localparam int unsigned RDY_PULSE_NS     = 8000;
  localparam int unsigned RDY_PULSE_CYCLES = (RDY_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [6:0]  ARA_ADDR         = 7'h0c;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_AACK  = 3'b010,
    ST_WDATA = 3'b011,
    ST_WACK  = 3'b100,
    ST_RDATA = 3'b101,
    ST_RACK  = 3'b110,
    ST_ARA   = 3'b111
  } tac_state_type;
endpackage : tac_pkg

// >>> core/tac_threshold_alert.sv
// Operation
// - queue code 11 disables, pin released high
// - assert after 1, 2 or 4 exceedances
// - gain field picks full-scale range
// - mode bit: continuous or single-shot
// - rate field sets conversion period
// - mode bit: hysteresis or window comparator
// - polarity bit: active low or high
// - latched alert held until conversion register read or response
// - 16-bit twos complement signed thresholds
// - high msb 1, low msb 0: ready
// - ready: status level or per-conversion pulse
// - thresholds reset to 8000h and 7fffh
module tac_threshold_alert #(
  parameter logic [6:0]  DEV_ADDR         = 7'h2a,
  parameter int unsigned CONV_8SPS_CYCLES = tac_pkg::CONV_8SPS_CYCLES
) (
  input  wire logic               sys_clk,
  input  wire logic               rstn,
  input  wire logic               scl_in,
  input  wire logic               sda_in,
  output logic                    sda_out,
  output logic                    sda_oe,
  input  wire logic signed [15:0] sample_in,
  output logic                    alert_out,
  output logic                    alert_oe
);
  import tac_pkg::*;

  tac_state_type      state_reg;
  logic [1:0]         scl_sync_reg;
  logic [1:0]         sda_sync_reg;
  logic               scl_q_reg;
  logic               sda_q_reg;
  logic [3:0]         bit_cnt_reg;
  logic [7:0]         shift_reg;
  logic [1:0]         byte_idx_reg;
  logic [1:0]         ptr_reg;
  logic [7:0]         wr_msb_reg;
  logic [15:0]        rd_word_reg;
  logic               master_ack_reg;
  logic               wr_pulse_reg;
  logic [15:0]        wr_data_reg;
  logic               read_clear_reg;
  logic               ara_won_reg;
  logic [15:0]        cfg_reg;
  logic [15:0]        lo_reg;
  logic [15:0]        hi_reg;
  logic               start_reg;
  logic               alert_act_reg;
  logic [2:0]         hit_cnt_reg;
  logic [2:0]         hit_next;
  logic [8:0]         rdy_cnt_reg;
  logic               rdy_act_reg;
  logic signed [15:0] result;
  logic               conv_done;
  logic               busy;
  logic               scl_s, sda_s, scl_rise, scl_fall, start_cond, stop_cond;
  logic [1:0]         que;
  logic               que_dis, rdy_mode, single, cmode, pol, lat;
  logic               above, below, exceed, release_ok, clear_evt, ara_ok;
  logic               active, level;
  logic [15:0]        rd_sel;

  assign scl_s      = scl_sync_reg[1];
  assign sda_s      = sda_sync_reg[1];
  assign scl_rise   = scl_s && !scl_q_reg;
  assign scl_fall   = !scl_s && scl_q_reg;
  assign start_cond = scl_s && scl_q_reg && sda_q_reg && !sda_s;
  assign stop_cond  = scl_s && scl_q_reg && !sda_q_reg && sda_s;

  assign que      = cfg_reg[CFG_QUE_LSB +: 2];
  assign que_dis  = (que == QUE_DISABLE);
  assign single   = cfg_reg[CFG_MODE_BIT];
  assign cmode    = cfg_reg[CFG_CMODE_BIT];
  assign pol      = cfg_reg[CFG_POL_BIT];
  assign lat      = cfg_reg[CFG_LAT_BIT];
  assign rdy_mode = hi_reg[15] && !lo_reg[15];

  function automatic logic [2:0] need_count(input logic [1:0] q);
    unique case (q)
      QUE_ONE:  need_count = 3'h1;
      QUE_TWO:  need_count = 3'h2;
      default:  need_count = 3'h4;
    endcase
  endfunction : need_count

  // signed compare on raw codes, so gain changes shift meaning
  assign above      = $signed(result) > $signed(hi_reg);
  assign below      = $signed(result) < $signed(lo_reg);
  assign exceed     = cmode ? (above || below) : above;
  assign release_ok = cmode ? !exceed : below;
  assign hit_next   = (hit_cnt_reg == 3'h4) ? 3'h4 : hit_cnt_reg + 3'h1;
  assign clear_evt  = read_clear_reg || ara_won_reg;
  assign ara_ok     = alert_act_reg && lat && !rdy_mode && !que_dis;

  always_comb begin
    unique case (ptr_reg)
      PTR_CONV: rd_sel = result;
      PTR_CFG:  rd_sel = {!busy, cfg_reg[14:0]};
      PTR_LO:   rd_sel = lo_reg;
      PTR_HI:   rd_sel = hi_reg;
    endcase
  end

  tac_conv_engine #(
    .PERIOD_8SPS (CONV_8SPS_CYCLES)
  ) u_engine (
    .sys_clk      (sys_clk),
    .rstn         (rstn),
    .continuous   (!single),
    .start_single (start_reg),
    .rate_sel     (cfg_reg[CFG_DR_LSB +: 3]),
    .gain_sel     (cfg_reg[CFG_PGA_LSB +: 3]),
    .sample_in    (sample_in),
    .result_reg   (result),
    .done_reg     (conv_done),
    .busy_reg     (busy)
  );

  // bus pins come from another timing domain
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_q_reg    <= 1'b1;
      sda_q_reg    <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      scl_q_reg    <= scl_s;
      sda_q_reg    <= sda_s;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg      <= ST_IDLE;
      bit_cnt_reg    <= 4'h0;
      shift_reg      <= 8'h0;
      byte_idx_reg   <= 2'h0;
      ptr_reg        <= PTR_CONV;
      wr_msb_reg     <= 8'h0;
      rd_word_reg    <= 16'h0;
      master_ack_reg <= 1'b0;
      wr_pulse_reg   <= 1'b0;
      wr_data_reg    <= 16'h0;
      read_clear_reg <= 1'b0;
      ara_won_reg    <= 1'b0;
      sda_oe         <= 1'b0;
    end else begin
      wr_pulse_reg   <= 1'b0;
      read_clear_reg <= 1'b0;
      ara_won_reg    <= 1'b0;
      if (start_cond) begin
        state_reg    <= ST_ADDR;
        bit_cnt_reg  <= 4'h0;
        byte_idx_reg <= 2'h0;
        sda_oe       <= 1'b0;
      end else if (stop_cond) begin
        state_reg <= ST_IDLE;
        sda_oe    <= 1'b0;
      end else begin
        unique case (state_reg)
          ST_IDLE: begin
          end
          ST_ADDR, ST_WDATA: begin
            if (scl_rise) begin
              shift_reg   <= {shift_reg[6:0], sda_s};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_cnt_reg == 4'h8) begin
              sda_oe <= 1'b1;
              if (state_reg == ST_WDATA) begin
                state_reg    <= ST_WACK;
                byte_idx_reg <= (byte_idx_reg == 2'h2) ? 2'h2 : byte_idx_reg + 2'h1;
                if (byte_idx_reg == 2'h0) ptr_reg <= shift_reg[1:0];
                if (byte_idx_reg == 2'h1) wr_msb_reg <= shift_reg;
                if (byte_idx_reg == 2'h2) begin
                  wr_pulse_reg <= 1'b1;
                  wr_data_reg  <= {wr_msb_reg, shift_reg};
                end
              end else if (shift_reg[7:1] == DEV_ADDR) begin
                state_reg      <= ST_AACK;
                master_ack_reg <= shift_reg[0];
                byte_idx_reg   <= 2'h3;
              end else if (shift_reg[7:1] == ARA_ADDR && shift_reg[0] && ara_ok) begin
                state_reg    <= ST_AACK;
                byte_idx_reg <= 2'h2;
              end else begin
                state_reg <= ST_IDLE;
                sda_oe    <= 1'b0;
              end
            end
          end
          ST_AACK: begin
            if (scl_fall) begin
              bit_cnt_reg <= 4'h0;
              if (byte_idx_reg == 2'h2) begin
                state_reg <= ST_ARA;
                shift_reg <= {DEV_ADDR, 1'b1};
                sda_oe    <= !DEV_ADDR[6];
              end else if (master_ack_reg) begin
                state_reg    <= ST_RDATA;
                byte_idx_reg <= 2'h0;
                rd_word_reg  <= rd_sel;
                shift_reg    <= rd_sel[15:8];
                sda_oe       <= !rd_sel[15];
              end else begin
                state_reg    <= ST_WDATA;
                byte_idx_reg <= 2'h0;
                sda_oe       <= 1'b0;
              end
            end
          end
          ST_WACK: begin
            if (scl_fall) begin
              state_reg   <= ST_WDATA;
              bit_cnt_reg <= 4'h0;
              sda_oe      <= 1'b0;
            end
          end
          ST_RDATA, ST_ARA: begin
            if (scl_rise) begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              // lost arbitration: a released one seen low
              if (state_reg == ST_ARA && !sda_oe && !sda_s) begin
                state_reg <= ST_IDLE;
              end
            end else if (scl_fall && bit_cnt_reg == 4'h8) begin
              sda_oe <= 1'b0;
              if (state_reg == ST_ARA) begin
                state_reg   <= ST_IDLE;
                ara_won_reg <= 1'b1;
              end else begin
                state_reg <= ST_RACK;
                if (byte_idx_reg == 2'h1 && ptr_reg == PTR_CONV) begin
                  read_clear_reg <= 1'b1;
                end
              end
            end else if (scl_fall) begin
              shift_reg <= {shift_reg[6:0], 1'b0};
              sda_oe    <= !shift_reg[6];
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              master_ack_reg <= !sda_s;
            end else if (scl_fall) begin
              bit_cnt_reg <= 4'h0;
              if (!master_ack_reg) begin
                state_reg <= ST_IDLE;
              end else begin
                state_reg    <= ST_RDATA;
                byte_idx_reg <= byte_idx_reg + 2'h1;
                shift_reg    <= byte_idx_reg[0] ? rd_word_reg[15:8] : rd_word_reg[7:0];
                sda_oe       <= byte_idx_reg[0] ? !rd_word_reg[15] : !rd_word_reg[7];
              end
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_reg   <= CFG_RESET;
      lo_reg    <= LO_RESET;
      hi_reg    <= HI_RESET;
      start_reg <= 1'b0;
    end else begin
      start_reg <= 1'b0;
      if (wr_pulse_reg) begin
        unique case (ptr_reg)
          PTR_CONV: begin
          end
          PTR_CFG: begin
            // status bit is not stored; writing one with the mode bit set starts a single shot
            cfg_reg   <= {1'b0, wr_data_reg[14:0]};
            start_reg <= wr_data_reg[CFG_OS_BIT] && wr_data_reg[CFG_MODE_BIT];
          end
          PTR_LO: lo_reg <= wr_data_reg;
          PTR_HI: hi_reg <= wr_data_reg;
        endcase
      end
    end
  end

  // a new exceedance wins over a clear in the same cycle
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      alert_act_reg <= 1'b0;
      hit_cnt_reg   <= 3'h0;
    end else if (que_dis || rdy_mode) begin
      alert_act_reg <= 1'b0;
      hit_cnt_reg   <= 3'h0;
    end else if (conv_done) begin
      hit_cnt_reg <= exceed ? hit_next : 3'h0;
      if (exceed && hit_next >= need_count(que)) begin
        alert_act_reg <= 1'b1;
      end else if ((!lat && release_ok) || (lat && clear_evt)) begin
        alert_act_reg <= 1'b0;
      end
    end else if (lat && clear_evt) begin
      alert_act_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdy_cnt_reg <= 9'h0;
      rdy_act_reg <= 1'b0;
    end else begin
      if (conv_done) rdy_cnt_reg <= 9'(RDY_PULSE_CYCLES);
      else if (rdy_cnt_reg != 9'h0) rdy_cnt_reg <= rdy_cnt_reg - 9'h1;
      rdy_act_reg <= single ? !busy : (rdy_cnt_reg != 9'h0);
    end
  end

  assign active = rdy_mode ? rdy_act_reg : alert_act_reg;
  assign level  = que_dis ? 1'b1 : (pol ? active : !active);

  // open drain: only ever pull low
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      alert_oe  <= 1'b0;
      alert_out <= 1'b0;
      sda_out   <= 1'b0;
    end else begin
      alert_oe  <= !level;
      alert_out <= 1'b0;
      sda_out   <= 1'b0;
    end
  end

  chk_queue_disable_high: assert property (@(posedge sys_clk) disable iff (!rstn)
    que_dis ##1 que_dis |-> !alert_oe) else $error("disabled comparator pulls pin");
  chk_queue_count_met: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(alert_act_reg) |-> $past(conv_done) && $past(exceed)
      && ($past(hit_next) >= need_count($past(que)))) else $error("alert before queue met");
  chk_window_below_sets: assert property (@(posedge sys_clk) disable iff (!rstn)
    (conv_done && cmode && below && que == QUE_ONE && !rdy_mode) |=> alert_act_reg)
    else $error("window low side missed");
  chk_trad_below_release: assert property (@(posedge sys_clk) disable iff (!rstn)
    (conv_done && !cmode && below && !lat && !above) |=> !alert_act_reg)
    else $error("hysteresis release missed");
  chk_polarity_low_drive: assert property (@(posedge sys_clk) disable iff (!rstn)
    $past(alert_act_reg && !pol && !que_dis && !rdy_mode) |-> alert_oe)
    else $error("active low alert not driven");
  chk_latch_alert_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
    (alert_act_reg && lat && !clear_evt && !que_dis && !rdy_mode && !wr_pulse_reg)
      |=> alert_act_reg) else $error("latched alert dropped");
  chk_signed_high_cmp: assert property (@(posedge sys_clk) disable iff (!rstn)
    (conv_done && !cmode && que == QUE_ONE && !rdy_mode && $signed(result) > $signed(hi_reg))
      |=> alert_act_reg) else $error("signed high compare failed");
  chk_ready_mode_comp: assert property (@(posedge sys_clk) disable iff (!rstn)
    rdy_mode |=> !alert_act_reg) else $error("comparator active in ready mode");
  chk_ready_pulse_width: assert property (@(posedge sys_clk) disable iff (!rstn)
    conv_done |=> rdy_cnt_reg == 9'(RDY_PULSE_CYCLES)) else $error("ready pulse not loaded");
  chk_ready_single_level: assert property (@(posedge sys_clk) disable iff (!rstn)
    single |=> rdy_act_reg == !$past(busy)) else $error("ready level not status");
  chk_threshold_reset: assert property (@(posedge sys_clk)
    !$past(rstn) && rstn |-> lo_reg == LO_RESET && hi_reg == HI_RESET)
    else $error("threshold reset value wrong");
endmodule : tac_threshold_alert

// >>> sim/tac_host_model.sv
module tac_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h2a
) (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  int         nak = 0;
  logic [7:0] q;
  logic       a;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // sample just before the fall: device bit stands until its synced fall
  task automatic bit_x(input logic b, output logic r);
    #50 sda_low = ~b;
    #50 scl = 1'b1;
    #95 r = sda;
    #5 scl = 1'b0;
  endtask : bit_x
  task automatic byte_x(input logic [7:0] d, input logic hb, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) bit_x(d[i], r[i]);
    bit_x(hb, a);
  endtask : byte_x
  task automatic send(input logic [7:0] d);
    byte_x(d, 1'b1, q);
    nak += a;
  endtask : send
  task automatic start();
    #100 sda_low = 1'b1;
    #100 scl = 1'b0;
  endtask : start
  task automatic stop();
    #50 sda_low = 1'b1;
    #50 scl = 1'b1;
    #100 sda_low = 1'b0;
    #100;
  endtask : stop
  task automatic wr(input logic [1:0] p, input logic [15:0] d);
    start();
    send({DEV_ADDR, 1'b0});
    send({6'h0, p});
    send(d[15:8]);
    send(d[7:0]);
    stop();
  endtask : wr
  task automatic rd(input logic [1:0] p, output logic [15:0] d);
    start();
    send({DEV_ADDR, 1'b0});
    send({6'h0, p});
    stop();
    start();
    send({DEV_ADDR, 1'b1});
    byte_x(8'hff, 1'b0, d[15:8]);
    byte_x(8'hff, 1'b1, d[7:0]);
    stop();
  endtask : rd
  // alert response read: one address byte back, then not acknowledged
  task automatic ara(output logic [7:0] r);
    start();
    send({7'h0c, 1'b1});
    byte_x(8'hff, 1'b1, r);
    stop();
  endtask : ara
endmodule : tac_host_model

// >>> sim/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tac_pkg::*;
  localparam int unsigned CONV = 400;
  localparam int          P    = 50;
  logic               sys_clk, rstn, scl, h_low, sda_out, sda_oe, alert_out, alert_oe;
  logic signed [15:0] smp, s;
  logic [15:0]        rd;
  wire logic          sda;
  int                 n_fail, n_tests, n, w;
  int                 cnt[3] = '{1, 2, 4};
  // pull-up: released line reads high
  assign sda = ~(h_low | sda_oe);
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
  tac_threshold_alert #(.DEV_ADDR(7'h2a), .CONV_8SPS_CYCLES(CONV)) DUT (
    .sys_clk(sys_clk), .rstn(rstn), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .sample_in(smp), .alert_out(alert_out), .alert_oe(alert_oe));
  tac_host_model #(.DEV_ADDR(7'h2a)) host (.scl(scl), .sda_low(h_low), .sda(sda));
  function automatic logic [15:0] cfg(logic [2:0] g, logic m, logic [2:0] r, logic [4:0] c);
    return {4'h0, g, m, r, c};
  endfunction : cfg
  // open drain: pulled low when asserted with polarity 0
  function automatic logic exp_oe(logic act, logic pol);
    return act ^ pol;
  endfunction : exp_oe
  function automatic logic [15:0] scale(logic signed [15:0] v, int g);
    return (g == 0) ? v : (g == 1) ? v * 3 / 2 : v * 6;
  endfunction : scale
  task automatic summarize();
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize
  task automatic wait_oe(input logic v, input int max);
    n = 0;
    while (alert_oe !== v) begin
      if (n == max) begin
        `CHK(alert_oe, v)
        summarize();
      end
      @(negedge sys_clk);
      n++;
    end
  endtask : wait_oe
  task automatic set_s(input logic signed [15:0] v);
    @(posedge sys_clk);
    smp <= v;
  endtask : set_s
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial begin
    rstn = 1'b0;
    smp = '0;
    n_fail = 0;
    n_tests = 0;
    void'($urandom(28));
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    `CHK(alert_oe, 1'b0)
    host.rd(PTR_LO, rd);
    `CHK(rd, LO_RESET)
    host.rd(PTR_HI, rd);
    `CHK(rd, HI_RESET)
    host.rd(PTR_CFG, rd);
    `CHK({rd[CFG_MODE_BIT], rd[4:0]}, 6'h23)
    $display("test reset done");
    host.wr(PTR_LO, 16'hff9c);
    host.wr(PTR_HI, 16'h0064);
    for (int q = 0; q < 3; q++) begin
      for (int pol = 0; pol < 2; pol++) begin
        host.wr(PTR_CFG, cfg(3'h0, 1'b0, DR_64SPS, {1'b0, 1'(pol), 1'b0, 2'(q)}));
        wait_oe(exp_oe(1'b0, 1'(pol)), 4 * P);
        set_s(16'(200 + $urandom % 20000));
        wait_oe(exp_oe(1'b1, 1'(pol)), 6 * P);
        `CHK(n >= (cnt[q] - 1) * P && n <= cnt[q] * P + 4, 1'b1)
        set_s(-16'(200 + $urandom % 20000));
        wait_oe(exp_oe(1'b0, 1'(pol)), 3 * P);
      end
    end
    $display("test queue and polarity done");
    host.wr(PTR_CFG, cfg(3'h0, 1'b0, DR_64SPS, 5'h10));
    wait_oe(1'b1, 4 * P);
    set_s(16'($urandom % 100));
    wait_oe(1'b0, 3 * P);
    $display("test window done");
    host.wr(PTR_CFG, cfg(3'h0, 1'b0, DR_64SPS, 5'h04));
    set_s(16'h1000);
    wait_oe(1'b1, 3 * P);
    set_s(-16'sh1000);
    repeat (3 * P) @(negedge sys_clk);
    `CHK(alert_oe, 1'b1)
    host.ara(rd[7:0]);
    `CHK(rd[7:0], {7'h2a, 1'b1})
    wait_oe(1'b0, 10);
    set_s(16'h1000);
    wait_oe(1'b1, 3 * P);
    set_s(-16'sh1000);
    host.rd(PTR_CONV, rd);
    `CHK(rd, 16'hf000)
    wait_oe(1'b0, 10);
    $display("test latch done");
    host.wr(PTR_CFG, cfg(3'h0, 1'b0, DR_64SPS, 5'h03));
    set_s(16'h2000);
    repeat (4 * P) @(negedge sys_clk);
    `CHK(alert_oe, 1'b0)
    $display("test disable done");
    foreach (cnt[i]) begin
      s = 16'(2 * ($urandom % 2000));
      host.wr(PTR_CFG, cfg(3'(i == 2 ? 3 : i), 1'b0, DR_64SPS, 5'h03));
      set_s(s);
      repeat (3 * P) @(posedge sys_clk);
      host.rd(PTR_CONV, rd);
      `CHK(rd, scale(s, i == 2 ? 3 : i))
    end
    $display("test gain done");
    host.wr(PTR_CFG, cfg(3'h0, 1'b0, DR_8SPS, 5'h00));
    host.wr(PTR_LO, 16'h0000);
    host.wr(PTR_HI, 16'h8000);
    wait_oe(1'b0, CONV);
    wait_oe(1'b1, CONV + 10);
    wait_oe(1'b0, 400);
    w = n;
    wait_oe(1'b1, CONV);
    `CHK(w, RDY_PULSE_CYCLES)
    `CHK(w + n, CONV)
    host.wr(PTR_CFG, cfg(3'h0, 1'b1, DR_8SPS, 5'h00));
    wait_oe(1'b1, 4 * P);
    host.wr(PTR_CFG, 16'h8000 | cfg(3'h0, 1'b1, DR_8SPS, 5'h00));
    wait_oe(1'b0, 400);
    wait_oe(1'b1, CONV + 10);
    `CHK(host.nak, 0)
    $display("test ready done");
    summarize();
  end
endmodule : tb_top
